// File: rtl/eepfe_pkg.sv
package eepfe_pkg;
    // control byte layout
    localparam int CB_CODE_MSB = 7;
    localparam int CB_CODE_LSB = 4;
    localparam int CB_CS_HIGH  = 3;
    localparam int CB_CS_LOW   = 2;
    localparam int CB_BLOCK    = 1;
    localparam int CB_RW       = 0;
    // device-type code, value is arbitrary
    localparam logic [3:0] DEV_CODE = 4'h6;
    // bit counter value of the acknowledge clock
    localparam logic [3:0] ACK_SLOT   = 4'h8;
    localparam int         ADDR_W     = 9;
    localparam int         PAGE_BYTES = 16;
    localparam int         PAGE_IDX_W = 4;
    localparam int         PAGE_HI_W  = ADDR_W - PAGE_IDX_W;
    // programming cycle time
    localparam int PROG_TIME_MS = 5;
    localparam int SYS_CLK_KHZ  = 200000;
    localparam int PROG_CYC     = PROG_TIME_MS * SYS_CLK_KHZ;

    typedef enum logic [5:0] {
        EEPFE_L_IDLE   = 6'h01,
        EEPFE_L_CTRL   = 6'h02,
        EEPFE_L_ADDR   = 6'h04,
        EEPFE_L_WDATA  = 6'h08,
        EEPFE_L_READ   = 6'h10,
        EEPFE_L_IGNORE = 6'h20
    } eepfe_lstate_t;

    typedef enum logic [2:0] {
        EEPFE_S_IDLE  = 3'h1,
        EEPFE_S_WRITE = 3'h2,
        EEPFE_S_WAIT  = 3'h4
    } eepfe_sstate_t;

    typedef logic [PAGE_BYTES-1:0][7:0] eepfe_page_t;
endpackage : eepfe_pkg

// File: rtl/eepfe_top.sv
`timescale 1ns/1ps

module eepfe_link
    import eepfe_pkg::*;
(
    input  wire logic                  i_link_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_scl,
    input  wire logic                  i_sda,
    output logic                       o_sda_out,
    output logic                       o_sda_oe,
    input  wire logic                  i_chip_select_pin_low,
    input  wire logic                  i_chip_select_pin_high,
    input  wire logic                  i_write_protect,
    input  wire logic                  i_low_supply,
    input  wire logic                  i_busy,
    input  wire logic [7:0]            i_hold_data,
    output logic                       o_commit_tgl,
    output logic                       o_read_tgl,
    output logic [eepfe_pkg::PAGE_HI_W-1:0] o_page_hi,
    output logic [eepfe_pkg::PAGE_BYTES-1:0] o_mask,
    output eepfe_pkg::eepfe_page_t     o_page
);
    import eepfe_pkg::*;

    typedef struct packed {
        logic                  scl_s1;
        logic                  scl_s2;
        logic                  scl_q;
        logic                  sda_s1;
        logic                  sda_s2;
        logic                  sda_q;
        logic                  wp_s1;
        logic                  wp_s2;
        logic                  lo_s1;
        logic                  lo_s2;
        logic                  by_s1;
        logic                  by_s2;
        eepfe_lstate_t         st;
        logic [3:0]            cnt;
        logic [7:0]            sh;
        logic [7:0]            tx;
        logic                  blk;
        logic [ADDR_W-1:0]     addr;
        logic [PAGE_BYTES-1:0] mask;
        eepfe_page_t           page;
        logic                  oe;
        logic                  commit;
        logic                  rdt;
    } eepfe_link_t;

    eepfe_link_t r;
    eepfe_link_t next_r;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;
    logic        match;

    always_comb begin
        next_r = r;
        next_r.scl_s1 = i_scl;
        next_r.scl_s2 = r.scl_s1;
        next_r.scl_q  = r.scl_s2;
        next_r.sda_s1 = i_sda;
        next_r.sda_s2 = r.sda_s1;
        next_r.sda_q  = r.sda_s2;
        next_r.wp_s1  = i_write_protect;
        next_r.wp_s2  = r.wp_s1;
        next_r.lo_s1  = i_low_supply;
        next_r.lo_s2  = r.lo_s1;
        next_r.by_s1  = i_busy;
        next_r.by_s2  = r.by_s1;
        rise  = r.scl_s2 & ~r.scl_q;
        fall  = ~r.scl_s2 & r.scl_q;
        // sda edges with scl held high are framing only
        start = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
        stop  = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
        match = (r.sh[CB_CODE_MSB:CB_CODE_LSB] == DEV_CODE)
              && (r.sh[CB_CS_HIGH] == i_chip_select_pin_high)
              && (r.sh[CB_CS_LOW] == i_chip_select_pin_low)
              && !r.by_s2;
        if (start) begin
            next_r.st   = EEPFE_L_CTRL;
            next_r.cnt  = 4'h0;
            next_r.oe   = 1'b0;
            next_r.mask = '0;
        end else if (stop) begin
            // write only if at least one byte was received, not protected, supply good
            if (r.st == EEPFE_L_WDATA && |r.mask && !r.wp_s2
                    && !r.lo_s2) begin
                next_r.commit = ~r.commit;
            end
            next_r.st = EEPFE_L_IDLE;
            next_r.oe = 1'b0;
        end else if (r.st != EEPFE_L_IDLE
                && r.st != EEPFE_L_IGNORE) begin
            if (rise) begin
                if (r.cnt != ACK_SLOT) begin
                    next_r.sh  = {r.sh[6:0], r.sda_s2};
                    next_r.tx  = {r.tx[6:0], 1'b0};
                    next_r.cnt = r.cnt + 4'h1;
                end else begin
                    next_r.cnt = 4'h0;
                    // own ack drives oe; released oe means host ack slot
                    if (r.st == EEPFE_L_READ && !r.oe) begin
                        if (r.sda_s2) begin
                            next_r.st = EEPFE_L_IGNORE;
                        end else begin
                            next_r.tx  = i_hold_data;
                            next_r.rdt = ~r.rdt;
                        end
                    end
                end
            end
            if (fall) begin
                next_r.oe = 1'b0;
                if (r.cnt == ACK_SLOT) begin
                    case (r.st)
                        EEPFE_L_CTRL: begin
                            if (match) begin
                                next_r.oe  = 1'b1;
                                next_r.blk = r.sh[CB_BLOCK];
                                if (r.sh[CB_RW]) begin
                                    next_r.st  = EEPFE_L_READ;
                                    next_r.tx  = i_hold_data;
                                    next_r.rdt = ~r.rdt;
                                end else begin
                                    next_r.st = EEPFE_L_ADDR;
                                end
                            end else begin
                                next_r.st = EEPFE_L_IGNORE;
                            end
                        end
                        EEPFE_L_ADDR: begin
                            next_r.addr = {r.blk, r.sh};
                            next_r.oe   = 1'b1;
                            next_r.st   = EEPFE_L_WDATA;
                        end
                        EEPFE_L_WDATA: begin
                            // page index wraps, so byte 17 overwrites byte 1
                            next_r.page[r.addr[PAGE_IDX_W-1:0]] = r.sh;
                            next_r.mask[r.addr[PAGE_IDX_W-1:0]] = 1'b1;
                            next_r.addr[PAGE_IDX_W-1:0] =
                                r.addr[PAGE_IDX_W-1:0] + 4'h1;
                            next_r.oe = 1'b1;
                        end
                        default: begin
                            next_r.oe = 1'b0;
                        end
                    endcase
                end else if (r.st == EEPFE_L_READ) begin
                    next_r.oe = ~r.tx[7];
                end
            end
        end
    end

    always_ff @(posedge i_link_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r        <= '0;
            r.scl_s1 <= 1'b1;
            r.scl_s2 <= 1'b1;
            r.scl_q  <= 1'b1;
            r.sda_s1 <= 1'b1;
            r.sda_s2 <= 1'b1;
            r.sda_q  <= 1'b1;
            r.st     <= EEPFE_L_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign o_sda_out    = 1'b0;
    assign o_sda_oe     = r.oe;
    assign o_commit_tgl = r.commit;
    assign o_read_tgl   = r.rdt;
    assign o_page_hi    = r.addr[ADDR_W-1:PAGE_IDX_W];
    assign o_mask       = r.mask;
    assign o_page       = r.page;
endmodule : eepfe_link

module eepfe_top
    import eepfe_pkg::*;
#(
    parameter int PROG_CYCLES = eepfe_pkg::PROG_CYC
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_link_clk,
    input  wire logic                     i_scl,
    input  wire logic                     i_sda,
    output logic                          o_sda_out,
    output logic                          o_sda_oe,
    input  wire logic                     i_chip_select_pin_low,
    input  wire logic                     i_chip_select_pin_high,
    input  wire logic                     i_write_protect,
    input  wire logic                     i_low_supply,
    input  wire logic [7:0]               i_rd_data,
    output logic                          o_rd_next,
    output logic                          o_busy,
    output logic                          o_wr_en,
    output logic [eepfe_pkg::ADDR_W-1:0]  o_wr_addr,
    output logic [7:0]                    o_wr_data
);
    import eepfe_pkg::*;

    typedef struct packed {
        logic                  cm_s1;
        logic                  cm_s2;
        logic                  cm_q;
        logic                  rd_s1;
        logic                  rd_s2;
        logic                  rd_q;
        logic                  lo_s1;
        logic                  lo_s2;
        eepfe_sstate_t         st;
        logic [PAGE_IDX_W-1:0] idx;
        logic [31:0]           tmr;
        logic                  busy;
        logic                  wr_en;
        logic [ADDR_W-1:0]     wr_addr;
        logic [7:0]            wr_data;
        logic                  rd_next;
        logic [7:0]            hold;
    } eepfe_sys_t;

    eepfe_sys_t                r;
    eepfe_sys_t                next_r;
    logic                      commit_tgl;
    logic                      read_tgl;
    logic [PAGE_HI_W-1:0]      page_hi;
    logic [PAGE_BYTES-1:0]     mask;
    eepfe_page_t               page;

    eepfe_link u_link (
        .i_link_clk             (i_link_clk),
        .i_rst_n                (i_rst_n),
        .i_scl                  (i_scl),
        .i_sda                  (i_sda),
        .o_sda_out              (o_sda_out),
        .o_sda_oe               (o_sda_oe),
        .i_chip_select_pin_low  (i_chip_select_pin_low),
        .i_chip_select_pin_high (i_chip_select_pin_high),
        .i_write_protect        (i_write_protect),
        .i_low_supply           (i_low_supply),
        .i_busy                 (r.busy),
        .i_hold_data            (r.hold),
        .o_commit_tgl           (commit_tgl),
        .o_read_tgl             (read_tgl),
        .o_page_hi              (page_hi),
        .o_mask                 (mask),
        .o_page                 (page)
    );

    // page and page_hi stay frozen while busy: no control byte is
    // acknowledged then; mask is still cleared by any start condition
    always_comb begin
        next_r = r;
        next_r.cm_s1   = commit_tgl;
        next_r.cm_s2   = r.cm_s1;
        next_r.cm_q    = r.cm_s2;
        next_r.rd_s1   = read_tgl;
        next_r.rd_s2   = r.rd_s1;
        next_r.rd_q    = r.rd_s2;
        next_r.lo_s1   = i_low_supply;
        next_r.lo_s2   = r.lo_s1;
        next_r.wr_en   = 1'b0;
        next_r.rd_next = r.rd_s2 ^ r.rd_q;
        if (r.rd_next) begin
            next_r.hold = i_rd_data;
        end
        case (r.st)
            EEPFE_S_IDLE: begin
                if ((r.cm_s2 ^ r.cm_q) && !r.lo_s2) begin
                    next_r.st   = EEPFE_S_WRITE;
                    next_r.idx  = '0;
                    next_r.busy = 1'b1;
                end
            end
            EEPFE_S_WRITE: begin
                next_r.wr_en   = mask[r.idx] & ~r.lo_s2;
                next_r.wr_addr = {page_hi, r.idx};
                next_r.wr_data = page[r.idx];
                next_r.idx     = r.idx + 4'h1;
                if (r.idx == 4'hF) begin
                    next_r.st  = EEPFE_S_WAIT;
                    next_r.tmr = 32'h0000_0010;
                end
            end
            EEPFE_S_WAIT: begin
                next_r.tmr = r.tmr + 32'h0000_0001;
                if (r.tmr >= 32'(PROG_CYCLES - 1)) begin
                    next_r.st   = EEPFE_S_IDLE;
                    next_r.busy = 1'b0;
                end
            end
            default: begin
                next_r.st   = EEPFE_S_IDLE;
                next_r.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            r    <= '0;
            r.st <= EEPFE_S_IDLE;
        end else begin
            r <= next_r;
        end
    end

    assign o_rd_next = r.rd_next;
    assign o_busy    = r.busy;
    assign o_wr_en   = r.wr_en;
    assign o_wr_addr = r.wr_addr;
    assign o_wr_data = r.wr_data;
endmodule : eepfe_top

// File: verification/eepfe_chk.sv
`timescale 1ns/1ps
module eepfe_chk
    import eepfe_pkg::*;
#(
    parameter int PROG_CYCLES = 100
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_link_clk,
    input  wire logic              i_scl,
    input  wire logic              o_sda_out,
    input  wire logic              o_sda_oe,
    input  wire logic              i_write_protect,
    input  wire logic              i_low_supply,
    input  wire logic              o_busy,
    input  wire logic              o_wr_en,
    input  wire logic [ADDR_W-1:0] o_wr_addr
);
    int busy_cnt;
    // length of the current programming cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            busy_cnt <= 0;
        else
            busy_cnt <= o_busy ? busy_cnt + 1 : 0;
    end
    sequence s_wr_pair;
        o_wr_en ##1 o_wr_en;
    endsequence
    chk_sda_no_high: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) o_sda_out == 1'b0)
        else $error("data line driven high");
    // a change of oe is seen one link edge after it is launched, so the
    // pin level at the launching edge is what must be low
    chk_oe_scl_low: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $past(i_rst_n) && $changed(o_sda_oe)
        |-> !$past(i_scl))
        else $error("data line changed while clock high");
    chk_ack_held_high: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $past(i_rst_n) && i_scl && $past(i_scl)
        |-> $stable(o_sda_oe))
        else $error("data line moved in clock high phase");
    chk_wp_no_write: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) o_wr_en |-> !i_write_protect)
        else $error("array write while protected");
    chk_low_vdd_inhibit: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) o_wr_en |-> !i_low_supply)
        else $error("array write at low supply");
    chk_write_in_busy: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) o_wr_en |-> o_busy)
        else $error("array write outside programming cycle");
    chk_busy_bounded: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) busy_cnt <= PROG_CYCLES)
        else $error("programming cycle too long");
    chk_no_ack_busy: assert property (@(posedge i_link_clk)
        disable iff (!i_rst_n) $rose(o_sda_oe) |-> !o_busy)
        else $error("data line pulled while programming");
    chk_page_incr: assert property (@(posedge i_sys_clk)
        disable iff (!i_rst_n) s_wr_pair |->
        o_wr_addr == {$past(o_wr_addr[8:4]), $past(o_wr_addr[3:0]) + 4'h1})
        else $error("page write address not stepping");
endmodule : eepfe_chk

bind eepfe_top eepfe_chk #(.PROG_CYCLES(PROG_CYCLES)) i_chk (
    .i_sys_clk, .i_rst_n, .i_link_clk, .i_scl, .o_sda_out, .o_sda_oe,
    .i_write_protect, .i_low_supply, .o_busy, .o_wr_en, .o_wr_addr);

// File: verification/eepfe_host.sv
`timescale 1ns/1ps
module eepfe_host #(
    parameter int QTR = 30
) (
    input  wire logic i_sys_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_low
);
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    task automatic wt();
        repeat (QTR) @(negedge i_sys_clk);
    endtask : wt
    // works from idle and as a repeated start
    task automatic start();
        o_sda_low = 1'b0;
        wt();
        o_scl = 1'b1;
        wt();
        o_sda_low = 1'b1;
        wt();
        o_scl = 1'b0;
    endtask : start
    task automatic stop();
        o_sda_low = 1'b1;
        wt();
        o_scl = 1'b1;
        wt();
        o_sda_low = 1'b0;
        wt();
        wt();
    endtask : stop
    // eight bits msb first, then the acknowledge slot; a 1 releases sda
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            wt();
            o_sda_low = !tx[i];
            wt();
            o_scl = 1'b1;
            wt();
            rx[i] = i_sda;
            wt();
            o_scl = 1'b0;
        end
    endtask : xfer
endmodule : eepfe_host

// File: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import eepfe_pkg::*;
    logic        sys_clk  = 1'b0;
    logic        link_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wp       = 1'b0;
    logic        lv       = 1'b0;
    logic [7:0]  rd_data  = 8'h00;
    logic        cs_lo, cs_hi, scl, sda_low, sda, sda_out, sda_oe;
    logic        rd_next, busy, wr_en;
    logic [8:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [16:0] exp_q[$];
    int          error_cnt = 0;
    int          n_checks  = 0;
    int          cyc       = 0;
    int          rd_cnt    = 0;
    int          seed      = 32'h4086;

    always #2.5 sys_clk = !sys_clk;
    always #24 link_clk = !link_clk;
    assign sda = (sda_oe ? sda_out : 1'b1) & !sda_low;

    // long enough that the poll after a commit still meets the busy cycle
    eepfe_top #(.PROG_CYCLES(1500)) i_dut (
        .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_link_clk(link_clk),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_chip_select_pin_low(cs_lo), .i_chip_select_pin_high(cs_hi),
        .i_write_protect(wp), .i_low_supply(lv), .i_rd_data(rd_data),
        .o_rd_next(rd_next), .o_busy(busy), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data));
    eepfe_host i_host (
        .i_sys_clk(sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("errors %0d checks %0d", error_cnt, n_checks);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // one write frame, then a poll while the page programs
    task automatic wr(input logic [7:0] cb, input logic [7:0] ad,
                      input int n, input logic ok, input logic commit);
        logic [8:0]  rx;
        logic [7:0]  pg[16];
        logic [15:0] m;
        logic [3:0]  idx;
        m   = 16'h0000;
        idx = ad[3:0];
        i_host.start();
        i_host.xfer({cb, 1'b1}, rx);
        chk({16'h0, rx[0]}, {16'h0, !ok});
        i_host.xfer({ad, 1'b1}, rx);
        chk({16'h0, rx[0]}, {16'h0, !ok});
        for (int i = 0; i < n; i++) begin
            pg[idx] = 8'($random(seed));
            m[idx]  = 1'b1;
            i_host.xfer({pg[idx], 1'b1}, rx);
            chk({16'h0, rx[0]}, 17'h0);
            idx++;
        end
        for (int i = 0; i < 16; i++)
            if (commit && m[i])
                exp_q.push_back({cb[1], ad[7:4], 4'(i), pg[i]});
        i_host.stop();
        i_host.start();
        i_host.xfer({cb, 1'b1}, rx);
        chk({16'h0, rx[0]}, {16'h0, !ok || commit});
        i_host.stop();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++)
            @(negedge sys_clk);
        chk({16'h0, busy}, 17'h0);
        repeat (20) @(negedge sys_clk);
        chk(17'(exp_q.size()), 17'h0);
    endtask : wr

    // outputs are looked at mid-cycle, away from the launching edge
    always @(negedge sys_clk) begin
        if (rd_next === 1'b1)
            rd_cnt++;
        if (wr_en === 1'b1) begin
            if (exp_q.size() == 0)
                chk({16'h0, wr_en}, 17'h0);
            else
                chk({wr_addr, wr_data}, exp_q.pop_front());
        end
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 95000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        logic [8:0] rx;
        logic [7:0] ok_cb;
        {cs_hi, cs_lo} = 2'($random(seed));
        ok_cb = {DEV_CODE, cs_hi, cs_lo, 1'b1, 1'b0};
        repeat (5) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (40) @(negedge sys_clk);
        wr(ok_cb, 8'($random(seed)) | 8'h0D, 3, 1'b1, 1'b1);
        wr(ok_cb & 8'hFD, 8'h5E, 17, 1'b1, 1'b1);
        for (int k = 0; k < 2; k++) begin
            {lv, wp} = k ? 2'b10 : 2'b01;
            wr(ok_cb, 8'($random(seed)), 2, 1'b1, 1'b0);
        end
        {lv, wp} = 2'b00;
        wr(ok_cb ^ 8'h80, 8'h10, 0, 1'b0, 1'b0);
        wr(ok_cb ^ 8'h08, 8'h10, 0, 1'b0, 1'b0);
        wr(ok_cb ^ 8'h04, 8'h10, 0, 1'b0, 1'b0);
        rd_data = 8'($random(seed));
        i_host.start();
        i_host.xfer({ok_cb | 8'h01, 1'b1}, rx);
        chk({16'h0, rx[0]}, 17'h0);
        i_host.xfer(9'h1FE, rx);
        chk({9'h0, rx[8:1]}, 17'h0);
        i_host.xfer(9'h1FF, rx);
        chk({9'h0, rx[8:1]}, {9'h0, rd_data});
        repeat (40) @(negedge sys_clk);
        chk({16'h0, sda}, 17'h1);
        chk(17'(rd_cnt), 17'h2);
        i_host.stop();
        conclude();
    end
endmodule : tb_top
